/* emprc_pkg.sv */
// shared constants and types for the emulator pause/run control block
package emprc_pkg;

  // refresh register image layout
  localparam int            IMG_IDX_W      = 2;
  localparam int            IMG_DEPTH      = 4;
  localparam int            REG_W          = 16;
  localparam logic [15:0]   REFRESH_RST    = 16'h0000;
  localparam int            REFRESH_EN_BIT = 15;

  // the enable register of one variant and the control register of the other share slot 2
  localparam logic [1:0]    CTRL_IDX       = 2'h2;
  localparam logic [1:0]    FIRST_IDX      = 2'h0;
  localparam logic [1:0]    LAST_IDX_BASIC = 2'h2;
  localparam logic [1:0]    LAST_IDX_EB    = 2'h3;
  localparam logic [1:0]    IDX_STEP       = 2'h1;

  // restart address on the 20-bit address bus
  localparam int            ADDR_W         = 20;
  localparam logic [19:0]   RESTART_ADDR   = 20'hFFFF0;

  // run command encoding: bit 0 arms breakpoints, bit 1 loads restart vectors
  localparam int            CMD_W          = 2;
  localparam int            CMD_BREAKS_BIT = 0;
  localparam int            CMD_VECTOR_BIT = 1;
  localparam logic [1:0]    CMD_RUN_PLAIN              = 2'h0;
  localparam logic [1:0]    CMD_RUN_WITH_BREAKS        = 2'h1;
  localparam logic [1:0]    CMD_VECTOR_RUN_NO_BREAKS   = 2'h2;
  localparam logic [1:0]    CMD_VECTOR_RUN_WITH_BREAKS = 2'h3;

  typedef enum logic [2:0] {
    ST_PAUSE,
    ST_SAVE,
    ST_SETTLE,
    ST_DISABLE,
    ST_LOAD,
    ST_START,
    ST_GO,
    ST_RUN
  } emprc_state_t;

endpackage

/* emprc_refresh_img.sv */
// stored image of the refresh registers, one capture port, one operator port, two read ports
`timescale 1ns/1ps
module emprc_refresh_img
  import emprc_pkg::*;
#(
  parameter int W     = REG_W,
  parameter int DEPTH = IMG_DEPTH,
  parameter int IW    = IMG_IDX_W
) (
  input  wire logic          clk_sys_i,
  input  wire logic          sys_rst_i,
  input  wire logic          clk_en_i,
  input  wire logic          cap_we_i,
  input  wire logic [IW-1:0] cap_idx_i,
  input  wire logic [W-1:0]  cap_data_i,
  input  wire logic          op_we_i,
  input  wire logic [IW-1:0] op_idx_i,
  input  wire logic [W-1:0]  op_data_i,
  input  wire logic [IW-1:0] rd_a_idx_i,
  output logic      [W-1:0]  rd_a_data_o,
  input  wire logic [IW-1:0] rd_b_idx_i,
  output logic      [W-1:0]  rd_b_data_o
);

  logic [W-1:0] img_r [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_entry
      wire cap_hit = cap_we_i && (cap_idx_i == IW'(g));
      wire op_hit  = op_we_i && (op_idx_i == IW'(g));
      always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          img_r[g] <= W'(REFRESH_RST);
        end else if (clk_en_i) begin
          // a live capture beats an operator edit of the same slot
          if (cap_hit) begin
            img_r[g] <= cap_data_i;
          end else if (op_hit) begin
            img_r[g] <= op_data_i;
          end
        end
      end
    end
  endgenerate

  assign rd_a_data_o = img_r[rd_a_idx_i];
  assign rd_b_data_o = img_r[rd_b_idx_i];

endmodule

/* emprc_top.sv */
// run/pause control: chip-select gating, trace filtering, refresh save/restore, run commands
`timescale 1ns/1ps
// Summary of operation
// - pause chip-select switch on: selects reach target
// - switch off: selects held inactive while paused
// - peek/poke traced when both trace switches on
// - peek/poke switch off: internal cycles not traced
// - three refresh registers basic, four on EB
// - refresh switch off: image written before run
// - refresh switch on: image not written at run
// - run-to-pause always reads refresh registers into image
// - refresh switch on: refresh runs, reads target
// - refresh switch off: clear enable bit 15
// - reset character forces refresh switch off
// - pause edits take effect entering run with refresh switch off
// - plain run commands start at code pointer, breaks chosen
// - vector runs load vectors, start restart address
// - vector runs accepted only while paused
// - breakpoint runs make all events active
module emprc_top
  import emprc_pkg::*;
#(
  parameter int CS_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              pause_chip_select_switch_i,
  input  wire logic              peek_poke_trace_switch_i,
  input  wire logic              trace_capture_switch_i,
  input  wire logic              refresh_sw_on_i,
  input  wire logic              refresh_sw_off_i,
  input  wire logic              reset_char_i,
  input  wire logic              variant_eb_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [CMD_W-1:0]  cmd_code_i,
  input  wire logic [ADDR_W-1:0] current_code_pointer_i,
  input  wire logic              pause_req_i,
  input  wire logic [CS_W-1:0]   cs_cpu_n_i,
  input  wire logic              cyc_valid_i,
  input  wire logic              cyc_internal_i,
  input  wire logic [REG_W-1:0]  pcb_rdata_i,
  input  wire logic              img_wr_i,
  input  wire logic [1:0]        img_idx_i,
  input  wire logic [REG_W-1:0]  img_wdata_i,
  output logic      [CS_W-1:0]   cs_target_n_o,
  output logic                   trace_store_o,
  output logic                   pcb_rd_o,
  output logic                   pcb_wr_o,
  output logic      [1:0]        pcb_idx_o,
  output logic      [REG_W-1:0]  pcb_wdata_o,
  output logic      [REG_W-1:0]  img_rdata_o,
  output logic                   pause_refresh_switch_o,
  output logic                   refresh_live_o,
  output logic                   read_to_target_o,
  output logic                   run_mode_o,
  output logic                   breaks_armed_o,
  output logic                   events_active_o,
  output logic                   load_vectors_o,
  output logic                   run_start_o,
  output logic      [ADDR_W-1:0] start_addr_o,
  output logic                   cmd_accept_o,
  output logic                   cmd_reject_o
);

  emprc_state_t state_r;
  emprc_state_t state_nxt;
  logic [1:0]   idx_r;
  logic [1:0]   idx_nxt;
  logic         pre_sw_r;
  logic         breaks_r;
  logic         vec_r;
  logic         rd_pend_r;
  logic [1:0]   rd_pend_idx_r;
  logic [REG_W-1:0] img_b_data;
  logic [REG_W-1:0] img_rdata_nxt;

  // decode
  wire       paused_w   = (state_r != ST_RUN);
  wire       idle_w     = (state_r == ST_PAUSE);
  wire [1:0] last_idx_w = variant_eb_i ? LAST_IDX_EB : LAST_IDX_BASIC;
  wire       at_last_w  = (idx_r == last_idx_w);
  wire       accept_w   = cmd_valid_i && idle_w;
  wire       reject_w   = cmd_valid_i && !idle_w;
  wire       cmd_brk_w  = cmd_code_i[CMD_BREAKS_BIT];
  wire       cmd_vec_w  = cmd_code_i[CMD_VECTOR_BIT];
  wire       break_w    = (state_r == ST_RUN) && pause_req_i;
  wire       op_we_w    = img_wr_i && idle_w;
  wire       save_rd_w  = (state_r == ST_SAVE);
  wire       load_wr_w  = (state_r == ST_LOAD);
  wire       dis_wr_w   = (state_r == ST_DISABLE);
  wire [1:0] img_b_idx  = dis_wr_w ? CTRL_IDX : idx_r;
  // cut the enable bit from the saved control value, keep the rest as read
  wire [REG_W-1:0] dis_val_w = img_b_data & ~(REG_W'(1) << REFRESH_EN_BIT);
  // chip selects forced inactive only while paused with the switch off
  wire [CS_W-1:0] cs_nxt = (paused_w && !pause_chip_select_switch_i) ? {CS_W{1'b1}} : cs_cpu_n_i;
  // internal cycles need both switches; target cycles need only capture
  wire trace_nxt = cyc_valid_i && trace_capture_switch_i
                   && (!cyc_internal_i || peek_poke_trace_switch_i);
  wire [ADDR_W-1:0] start_nxt = vec_r ? RESTART_ADDR : current_code_pointer_i;

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    case (state_r)
      ST_PAUSE: begin
        if (accept_w) begin
          idx_nxt   = FIRST_IDX;
          state_nxt = pre_sw_r ? ST_START : ST_LOAD;
        end
      end
      ST_LOAD: begin
        idx_nxt = idx_r + IDX_STEP;
        if (at_last_w) begin
          state_nxt = ST_START;
        end
      end
      ST_START: state_nxt = ST_GO;
      ST_GO:    state_nxt = ST_RUN;
      ST_RUN: begin
        if (break_w) begin
          idx_nxt   = FIRST_IDX;
          state_nxt = ST_SAVE;
        end
      end
      ST_SAVE: begin
        idx_nxt = idx_r + IDX_STEP;
        if (at_last_w) begin
          state_nxt = ST_SETTLE;
        end
      end
      // wait for the last read to land in the image before deciding
      ST_SETTLE: begin
        if (!pcb_rd_o && !rd_pend_r) begin
          state_nxt = pre_sw_r ? ST_PAUSE : ST_DISABLE;
        end
      end
      ST_DISABLE: state_nxt = ST_PAUSE;
      default:    state_nxt = ST_PAUSE;
    endcase
  end

  // sequencer
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r  <= ST_PAUSE;
      idx_r    <= FIRST_IDX;
      breaks_r <= 1'b0;
      vec_r    <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      if (accept_w) begin
        breaks_r <= cmd_brk_w;
        vec_r    <= cmd_vec_w;
      end
    end
  end

  // refresh switch: the reset character overrides any on request
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pre_sw_r <= 1'b0;
    end else if (clk_en_i) begin
      if (reset_char_i || refresh_sw_off_i) begin
        pre_sw_r <= 1'b0;
      end else if (refresh_sw_on_i) begin
        pre_sw_r <= 1'b1;
      end
    end
  end

  // peripheral block access; read data answers one cycle after the strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pcb_rd_o      <= 1'b0;
      pcb_wr_o      <= 1'b0;
      pcb_idx_o     <= FIRST_IDX;
      pcb_wdata_o   <= REFRESH_RST;
      rd_pend_r     <= 1'b0;
      rd_pend_idx_r <= FIRST_IDX;
    end else if (clk_en_i) begin
      pcb_rd_o      <= save_rd_w;
      pcb_wr_o      <= load_wr_w || dis_wr_w;
      pcb_idx_o     <= img_b_idx;
      pcb_wdata_o   <= dis_wr_w ? dis_val_w : img_b_data;
      rd_pend_r     <= pcb_rd_o;
      rd_pend_idx_r <= pcb_idx_o;
    end
  end

  emprc_refresh_img #(
    .W     (REG_W),
    .DEPTH (IMG_DEPTH),
    .IW    (IMG_IDX_W)
  ) u_img (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .clk_en_i    (clk_en_i),
    .cap_we_i    (rd_pend_r),
    .cap_idx_i   (rd_pend_idx_r),
    .cap_data_i  (pcb_rdata_i),
    .op_we_i     (op_we_w),
    .op_idx_i    (img_idx_i),
    .op_data_i   (img_wdata_i),
    .rd_a_idx_i  (img_idx_i),
    .rd_a_data_o (img_rdata_nxt),
    .rd_b_idx_i  (img_b_idx),
    .rd_b_data_o (img_b_data)
  );

  // status and target-facing outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      cs_target_n_o          <= {CS_W{1'b1}};
      trace_store_o          <= 1'b0;
      img_rdata_o            <= REFRESH_RST;
      pause_refresh_switch_o <= 1'b0;
      refresh_live_o         <= 1'b0;
      read_to_target_o       <= 1'b0;
      run_mode_o             <= 1'b0;
      breaks_armed_o         <= 1'b0;
      events_active_o        <= 1'b0;
      load_vectors_o         <= 1'b0;
      run_start_o            <= 1'b0;
      start_addr_o           <= RESTART_ADDR;
      cmd_accept_o           <= 1'b0;
      cmd_reject_o           <= 1'b0;
    end else if (clk_en_i) begin
      cs_target_n_o          <= cs_nxt;
      trace_store_o          <= trace_nxt;
      img_rdata_o            <= img_rdata_nxt;
      pause_refresh_switch_o <= pre_sw_r;
      refresh_live_o         <= !paused_w || pre_sw_r;
      read_to_target_o       <= paused_w && pre_sw_r;
      run_mode_o             <= (state_nxt == ST_RUN);
      breaks_armed_o         <= (state_nxt == ST_RUN) && breaks_r;
      events_active_o        <= (state_nxt == ST_RUN) && breaks_r;
      // vectors go out one cycle ahead of the start pulse
      load_vectors_o         <= (state_r == ST_START) && vec_r;
      run_start_o            <= (state_r == ST_GO);
      if (state_r == ST_GO) begin
        start_addr_o <= start_nxt;
      end
      cmd_accept_o <= accept_w;
      cmd_reject_o <= reject_w;
    end
  end

  cs_held_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && paused_w && !pause_chip_select_switch_i |=> cs_target_n_o == {CS_W{1'b1}})
    else $error("chip selects not held inactive in pause");

  cs_pass_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && (!paused_w || pause_chip_select_switch_i) |=> cs_target_n_o == $past(cs_cpu_n_i))
    else $error("chip selects not passed to target");

  trace_drop_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && cyc_valid_i && cyc_internal_i && !peek_poke_trace_switch_i |=> !trace_store_o)
    else $error("internal cycle traced with switch off");

  trace_keep_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && cyc_valid_i && peek_poke_trace_switch_i && trace_capture_switch_i |=> trace_store_o)
    else $error("internal cycle not traced");

  cmd_reject_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && cmd_valid_i && cmd_vec_w && !idle_w |=> cmd_reject_o && !cmd_accept_o && $stable(vec_r) && $stable(breaks_r))
    else $error("vector run accepted outside pause");

  refresh_force_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && reset_char_i |=> !pre_sw_r)
    else $error("reset character did not clear refresh switch");

  image_kept_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    accept_w && pre_sw_r |=> !pcb_wr_o [*4])
    else $error("refresh image written with switch on");

  enable_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && dis_wr_w |=> pcb_wr_o && pcb_idx_o == CTRL_IDX && !pcb_wdata_o[REFRESH_EN_BIT])
    else $error("refresh enable bit not cleared on pause");

  save_read_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    break_w |=> ##1 pcb_rd_o && pcb_idx_o == FIRST_IDX)
    else $error("refresh registers not read on pause entry");

  vector_start_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    load_vectors_o |=> run_start_o && start_addr_o == RESTART_ADDR)
    else $error("vector run did not start at restart address");

  events_on_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    accept_w && cmd_brk_w && pre_sw_r |-> ##3 events_active_o && run_mode_o)
    else $error("events not active during breakpoint run");

  image_load_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    accept_w && !pre_sw_r |=> ##1 pcb_wr_o && pcb_idx_o == FIRST_IDX)
    else $error("refresh image not written before run");

  plain_start_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
    (state_r == ST_GO) && !vec_r |=> run_start_o && start_addr_o == $past(current_code_pointer_i))
    else $error("plain run did not start at code pointer");

  read_target_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    clk_en_i && paused_w && pre_sw_r |=> read_to_target_o && refresh_live_o)
    else $error("refresh not kept running in pause");

endmodule

/* emprc_pcb_model.sv */
// behavioural peripheral block holding the refresh registers, answering reads one cycle late
`timescale 1ns/1ps
module emprc_pcb_model
  import emprc_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             pcb_rd_i,
  input  wire logic             pcb_wr_i,
  input  wire logic [1:0]       pcb_idx_i,
  input  wire logic [REG_W-1:0] pcb_wdata_i,
  output logic      [REG_W-1:0] pcb_rdata_o
);
  logic [REG_W-1:0] regs_r [IMG_DEPTH];

  initial begin
    pcb_rdata_o = 16'h0000;
    foreach (regs_r[i]) regs_r[i] = 16'h0000;
  end

  // outside the answer cycle the bus toggles so a late capture shows up as garbage
  always @(posedge clk_sys_i) begin
    if (pcb_wr_i) begin
      regs_r[pcb_idx_i] <= pcb_wdata_i;
    end
    if (pcb_rd_i) begin
      pcb_rdata_o <= regs_r[pcb_idx_i];
    end else begin
      pcb_rdata_o <= ~pcb_rdata_o;
    end
  end
endmodule

/* emulator_pause_run_control_tb.sv */
// self-checking bench for the run/pause control block
`timescale 1ns/1ps
module emulator_pause_run_control_tb
  import emprc_pkg::*;
;
  logic clk_sys_i = 0, sys_rst_i = 1, cs_sw = 0, pp_sw = 0, cap_sw = 0, sw_on = 0, sw_off = 0, rchar = 0, eb = 0;
  logic cmd_v = 0, preq = 0, cyc_v = 0, cyc_int = 0, img_wr = 0, en = 1;
  logic [1:0] cmd = 2'h0, img_idx = 2'h0;
  logic [7:0] cs_cpu_n = 8'h5A, cs_n;
  logic [15:0] img_wd = 16'h0000, rdata, wdata, img_rd;
  logic [19:0] ptr = 20'h12345, start;
  logic [1:0] pidx;
  logic trace, prd, pwr, psw, live, rtt, run, brk, evt, vec_p, rst_o, acc, rej;
  int n_errors = 0, cmp_count = 0, n_rd = 0, n_wr = 0, n_ld = 0, n_rej = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;

  emprc_top #(.CS_W(8)) i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(en),
    .pause_chip_select_switch_i(cs_sw), .peek_poke_trace_switch_i(pp_sw), .trace_capture_switch_i(cap_sw),
    .refresh_sw_on_i(sw_on), .refresh_sw_off_i(sw_off), .reset_char_i(rchar), .variant_eb_i(eb),
    .cmd_valid_i(cmd_v), .cmd_code_i(cmd), .current_code_pointer_i(ptr), .pause_req_i(preq),
    .cs_cpu_n_i(cs_cpu_n), .cyc_valid_i(cyc_v), .cyc_internal_i(cyc_int), .pcb_rdata_i(rdata),
    .img_wr_i(img_wr), .img_idx_i(img_idx), .img_wdata_i(img_wd), .cs_target_n_o(cs_n),
    .trace_store_o(trace), .pcb_rd_o(prd), .pcb_wr_o(pwr), .pcb_idx_o(pidx), .pcb_wdata_o(wdata),
    .img_rdata_o(img_rd), .pause_refresh_switch_o(psw), .refresh_live_o(live), .read_to_target_o(rtt),
    .run_mode_o(run), .breaks_armed_o(brk), .events_active_o(evt), .load_vectors_o(vec_p),
    .run_start_o(rst_o), .start_addr_o(start), .cmd_accept_o(acc), .cmd_reject_o(rej));

  emprc_pcb_model i_pcb (.clk_sys_i(clk_sys_i), .pcb_rd_i(prd), .pcb_wr_i(pwr), .pcb_idx_i(pidx),
    .pcb_wdata_i(wdata), .pcb_rdata_o(rdata));

  // strobe tallies, cleared between phases by the tasks (n_rej by the main sequence)
  always @(posedge clk_sys_i) begin
    n_rd <= n_rd + int'(prd);
    n_wr <= n_wr + int'(pwr);
    n_ld <= n_ld + int'(vec_p);
    n_rej <= n_rej + int'(rej);
  end

  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic do_cmd(input logic [1:0] c);
    int k;
    n_wr = 0;
    n_ld = 0;
    cmd = c;
    cmd_v = 1;
    tick(1);
    cmd_v = 0;
    chk("accept", 20'h1, 20'(acc));
    for (k = 0; k < 30 && run !== 1'b1; k++) tick(1);
    chk("run_mode", 20'h1, 20'(run));
    chk("run_start", 20'h1, 20'(rst_o));
  endtask

  task automatic do_pause();
    n_rd = 0;
    n_wr = 0;
    preq = 1;
    tick(1);
    preq = 0;
    tick(15);
    chk("run_mode", 20'h0, 20'(run));
  endtask

  task automatic img_read(input logic [1:0] i, input logic [15:0] e);
    img_idx = i;
    tick(2);
    chk("img_rdata", 20'(e), 20'(img_rd));
  endtask

  initial begin
    tick(20);
    sys_rst_i = 0;
    chk("cs_reset", 20'hFF, 20'(cs_n));
    chk("start_reset", 20'hFFFF0, start);
    chk("switch_reset", 20'h0, 20'(psw));
    tick(2);
    chk("cs_pause_off", 20'hFF, 20'(cs_n));
    cs_sw = 1;
    tick(2);
    chk("cs_pause_on", 20'h5A, 20'(cs_n));
    // clock enable low must freeze the outputs
    en = 0;
    cs_sw = 0;
    tick(2);
    chk("cs_frozen", 20'h5A, 20'(cs_n));
    en = 1;
    for (int i = 0; i < 8; i++) begin
      {cyc_int, pp_sw, cap_sw} = 3'(i);
      cyc_v = 1;
      tick(1);
      chk("trace", 20'(cap_sw & (~cyc_int | pp_sw)), 20'(trace));
    end
    cyc_v = 0;
    // operator edits of the image while paused
    for (int i = 0; i < 3; i++) begin
      img_idx = 2'(i);
      img_wd = (i == 2) ? 16'h8ABC : 16'(16'h1111 * (i + 1));
      img_wr = 1;
      tick(1);
    end
    img_wr = 0;
    img_read(2'h1, 16'h2222);
    do_cmd(CMD_RUN_PLAIN);
    chk("writes", 20'd3, 20'(n_wr));
    chk("pcb0", 20'h1111, 20'(i_pcb.regs_r[0]));
    chk("pcb2", 20'h8ABC, 20'(i_pcb.regs_r[2]));
    chk("start", ptr, start);
    chk("breaks", 20'h0, 20'(brk));
    tick(1);
    chk("cs_run", 20'h5A, 20'(cs_n));
    n_rej = 0;
    cmd = CMD_VECTOR_RUN_WITH_BREAKS;
    cmd_v = 1;
    tick(1);
    cmd_v = 0;
    tick(2);
    chk("reject", 20'h1, 20'(n_rej));
    chk("no_vectors", 20'h0, 20'(n_ld));
    i_pcb.regs_r[0] = 16'h0AAA;
    do_pause();
    chk("reads", 20'd3, 20'(n_rd));
    img_read(2'h0, 16'h0AAA);
    chk("enable_cleared", 20'h0ABC, 20'(i_pcb.regs_r[2]));
    chk("cs_paused", 20'hFF, 20'(cs_n));
    sw_on = 1;
    tick(1);
    sw_on = 0;
    tick(1);
    chk("switch", 20'h1, 20'(psw));
    chk("live", 20'h1, 20'(live));
    chk("to_target", 20'h1, 20'(rtt));
    do_cmd(CMD_VECTOR_RUN_WITH_BREAKS);
    chk("no_restore", 20'h0, 20'(n_wr));
    chk("vectors", 20'h1, 20'(n_ld));
    chk("start", 20'hFFFF0, start);
    chk("breaks", 20'h1, 20'(brk));
    chk("events", 20'h1, 20'(evt));
    do_pause();
    chk("no_disable", 20'h0, 20'(n_wr));
    chk("live_pause", 20'h1, 20'(live));
    sw_off = 1;
    tick(1);
    sw_off = 0;
    tick(1);
    chk("switch_off", 20'h0, 20'(psw));
    chk("live_off", 20'h0, 20'(live));
    chk("to_target_off", 20'h0, 20'(rtt));
    sw_on = 1;
    rchar = 1;
    tick(1);
    sw_on = 0;
    rchar = 0;
    tick(1);
    chk("switch_char", 20'h0, 20'(psw));
    eb = 1;
    do_cmd(CMD_RUN_WITH_BREAKS);
    chk("writes_eb", 20'd4, 20'(n_wr));
    chk("start", ptr, start);
    chk("breaks", 20'h1, 20'(brk));
    chk("events", 20'h1, 20'(evt));
    do_pause();
    chk("reads_eb", 20'd4, 20'(n_rd));
    do_cmd(CMD_VECTOR_RUN_NO_BREAKS);
    chk("vectors", 20'h1, 20'(n_ld));
    chk("start", 20'hFFFF0, start);
    chk("breaks", 20'h0, 20'(brk));
    conclude();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule
